// [logic/power_event_status_enable.v]
`timescale 1ns/100ps
`include "power_event_defs.vh"

module power_event_status_enable #(
   parameter OVERRIDE_CYCLES = `OVERRIDE_CYCLES,
   parameter COUNT_WIDTH     = 32
) (
   // Clock and reset
   input  wire        clock,
   input  wire        nrst,
   // Register port
   input  wire        reg_select_valid,
   input  wire [1:0]  reg_select,
   input  wire        reg_write,
   input  wire [1:0]  byte_enable,
   input  wire [15:0] write_data,
   output reg  [15:0] read_data,
   // Event sources
   input  wire        power_key_pin,
   input  wire        sleep_key_pin,
   input  wire        alarm_request,
   input  wire        counter_msb,
   input  wire        global_attention_set,
   input  wire        bus_master_request,
   // Configuration
   input  wire        event_route_select,
   input  wire        deep_sleep_alarm_wake_flag,
   input  wire        sleep_enter,
   input  wire [2:0]  sleep_type,
   // Outputs
   output reg         os_event_interrupt,
   output reg         firmware_event_interrupt,
   output reg  [2:0]  power_state
);

// ---------------------------------------------------------------
// State codes
// ---------------------------------------------------------------
localparam [2:0] WORKING  = `ST_WORKING;
localparam [2:0] SLEEP1   = `ST_SLEEP1;
localparam [2:0] SLEEP2   = `ST_SLEEP2;
localparam [2:0] SLEEP3   = `ST_SLEEP3;
localparam [2:0] SLEEP4   = `ST_SLEEP4;
localparam [2:0] SOFT_OFF = `ST_SOFT_OFF;

// ---------------------------------------------------------------
// Helpers
// ---------------------------------------------------------------
function [15:0] byte_mask;
   input [1:0] be;
   begin
      byte_mask = {{8{be[1]}}, {8{be[0]}}};
   end
endfunction

// Byte-lane merge of a write into an enable bank; reserved bits
// are dropped so that they always read back as zero
function [15:0] merge_bytes;
   input [15:0] old_value;
   input [15:0] new_value;
   input [15:0] lanes;
   begin
      merge_bytes = ((old_value & ~lanes) | (new_value & lanes)) &
                    `ENABLE_MASK;
   end
endfunction

// ---------------------------------------------------------------
// Synchronisers and edges
// ---------------------------------------------------------------
reg [1:0] power_sync;
reg [1:0] sleep_sync;
reg [1:0] alarm_sync;
reg       power_prev;
reg       sleep_prev;
reg       alarm_prev;
reg       msb_prev;

// Power button: two flops into the clock domain, then an edge
always @(posedge clock or negedge nrst) begin
   if (!nrst) begin
      power_sync <= 2'h0;
      power_prev <= 1'b0;
   end else begin
      power_sync <= {power_sync[0], power_key_pin};
      power_prev <= power_sync[1];
   end
end

// Sleep button
always @(posedge clock or negedge nrst) begin
   if (!nrst) begin
      sleep_sync <= 2'h0;
      sleep_prev <= 1'b0;
   end else begin
      sleep_sync <= {sleep_sync[0], sleep_key_pin};
      sleep_prev <= sleep_sync[1];
   end
end

// Alarm request; the counter MSB is already on this clock
always @(posedge clock or negedge nrst) begin
   if (!nrst) begin
      alarm_sync <= 2'h0;
      alarm_prev <= 1'b0;
      msb_prev   <= 1'b0;
   end else begin
      alarm_sync <= {alarm_sync[0], alarm_request};
      alarm_prev <= alarm_sync[1];
      msb_prev   <= counter_msb;
   end
end

wire power_press = power_sync[1] & ~power_prev;
wire sleep_press = sleep_sync[1] & ~sleep_prev;
wire alarm_rise  = alarm_sync[1] & ~alarm_prev;
wire tick_carry  = counter_msb ^ msb_prev;

// ---------------------------------------------------------------
// Override counter
// ---------------------------------------------------------------
// Counts only while the synchronised power pin stays high and
// parks at the limit, so the override holds until release
reg  [COUNT_WIDTH-1:0] hold_count;
reg  [COUNT_WIDTH-1:0] next_hold_count;
wire [COUNT_WIDTH-1:0] hold_limit;
wire                   override;

assign hold_limit = OVERRIDE_CYCLES[COUNT_WIDTH-1:0];
assign override   = (hold_count == hold_limit);

always @* begin
   next_hold_count = hold_count;
   if (!power_sync[1]) begin
      next_hold_count = {COUNT_WIDTH{1'b0}};
   end else if (!override) begin
      next_hold_count = hold_count + 1'b1;
   end
end

always @(posedge clock or negedge nrst) begin
   if (!nrst) begin
      hold_count <= {COUNT_WIDTH{1'b0}};
   end else begin
      hold_count <= next_hold_count;
   end
end

// ---------------------------------------------------------------
// Registers
// ---------------------------------------------------------------
reg  [15:0] status;
reg  [15:0] enable_a;
reg  [15:0] enable_b;
wire [15:0] enable = enable_a | enable_b;
wire        asleep = (power_state != WORKING);

wire wr_status = reg_select_valid & reg_write &
                 (reg_select == `REG_STATUS);
wire wr_en_a   = reg_select_valid & reg_write &
                 (reg_select == `REG_ENABLE_A);
wire wr_en_b   = reg_select_valid & reg_write &
                 (reg_select == `REG_ENABLE_B);
wire [15:0] wmask = byte_mask(byte_enable);

// Wake sources while asleep; a power press wakes whatever its
// enable holds, the other sources only through their enables
wire power_wake = power_press;
wire sleep_wake = sleep_press & enable[`BIT_SLEEP_KEY];
wire alarm_wake = alarm_rise & enable[`BIT_ALARM] &
   ((power_state != SLEEP4) | deep_sleep_alarm_wake_flag);
wire wake_event = asleep &
   (power_wake | sleep_wake | alarm_wake);

// ---------------------------------------------------------------
// Flag set sources
// ---------------------------------------------------------------
// Button flags latch on every press, enabled or not
wire power_flag_set = power_press;
wire sleep_flag_set = sleep_press;
// In sleep 4 the alarm flag needs the alarm-wake configuration
wire alarm_flag_set = alarm_rise &
   ((power_state != SLEEP4) | deep_sleep_alarm_wake_flag);

// ---------------------------------------------------------------
// Status register
// ---------------------------------------------------------------
reg [15:0] set_bits;
reg [15:0] next_status;
always @* begin
   set_bits = 16'h0000;
   set_bits[`BIT_TICK]       = tick_carry;
   set_bits[`BIT_BUS_MASTER] = bus_master_request;
   set_bits[`BIT_GLOBAL]     = global_attention_set;
   set_bits[`BIT_POWER_KEY]  = power_flag_set;
   set_bits[`BIT_SLEEP_KEY]  = sleep_flag_set;
   set_bits[`BIT_ALARM]      = alarm_flag_set;
   set_bits[`BIT_WAKE]       = wake_event;
   next_status = status;
   if (wr_status)
      next_status = status & ~(write_data & wmask);
   if (override)
      next_status[`BIT_POWER_KEY] = 1'b0;
   next_status = (next_status | set_bits) & `STATUS_MASK;
end

always @(posedge clock or negedge nrst) begin
   if (!nrst)
      status <= 16'h0000;
   else
      status <= next_status;
end

// ---------------------------------------------------------------
// Enable registers
// ---------------------------------------------------------------
// Enables cleared on the override and when leaving soft-off for working
wire        from_off = (power_state == SOFT_OFF) & wake_event;
reg  [15:0] next_enable_a;
reg  [15:0] next_enable_b;

always @* begin
   next_enable_a = enable_a;
   next_enable_b = enable_b;
   if (wr_en_a) begin
      next_enable_a = merge_bytes(enable_a, write_data, wmask);
   end
   if (wr_en_b) begin
      next_enable_b = merge_bytes(enable_b, write_data, wmask);
   end
   if (from_off | override) begin
      next_enable_a = `ENABLE_RESET;
      next_enable_b = `ENABLE_RESET;
   end
end

always @(posedge clock or negedge nrst) begin
   if (!nrst) begin
      enable_a <= `ENABLE_RESET;
      enable_b <= `ENABLE_RESET;
   end else begin
      enable_a <= next_enable_a;
      enable_b <= next_enable_b;
   end
end

// ---------------------------------------------------------------
// Power state
// ---------------------------------------------------------------
reg [2:0] next_power_state;

always @* begin
   next_power_state = power_state;
   if (override) begin
      next_power_state = SOFT_OFF;
   end else if (wake_event) begin
      next_power_state = WORKING;
   end else if (!asleep && sleep_enter) begin
      case (sleep_type)
         SLEEP1,
         SLEEP2,
         SLEEP3,
         SLEEP4,
         SOFT_OFF: next_power_state = sleep_type;
         default:  next_power_state = power_state;
      endcase
   end
end

always @(posedge clock or negedge nrst) begin
   if (!nrst) begin
      power_state <= WORKING;
   end else begin
      power_state <= next_power_state;
   end
end

// ---------------------------------------------------------------
// Interrupt and read-back
// ---------------------------------------------------------------
// Bus-master status never interrupts
wire [15:0] gated   = status & enable &
                      ~(16'h0001 << `BIT_BUS_MASTER);
// Interrupts only in the working state
wire        pending = ~asleep & (|gated);

reg  [15:0] next_read_data;
reg         next_os_interrupt;
reg         next_fw_interrupt;

always @* begin
   next_os_interrupt = pending & event_route_select;
   next_fw_interrupt = pending & ~event_route_select;
   case (reg_select)
      `REG_STATUS:   next_read_data = status;
      `REG_ENABLE_A: next_read_data = enable_a;
      `REG_ENABLE_B: next_read_data = enable_b;
      default:       next_read_data = 16'h0000;
   endcase
end

always @(posedge clock or negedge nrst) begin
   if (!nrst) begin
      os_event_interrupt       <= 1'b0;
      firmware_event_interrupt <= 1'b0;
      read_data                <= 16'h0000;
   end else begin
      os_event_interrupt       <= next_os_interrupt;
      firmware_event_interrupt <= next_fw_interrupt;
      read_data                <= next_read_data;
   end
end

endmodule // power_event_status_enable

// [logic/power_event_defs.vh]
`ifndef POWER_EVENT_DEFS_VH
`define POWER_EVENT_DEFS_VH

// Register select on the byte/word I/O port
`define REG_STATUS       2'h0
`define REG_ENABLE_A     2'h1
`define REG_ENABLE_B     2'h2

// Bit positions, shared by status and enable
`define BIT_TICK         0
`define BIT_BUS_MASTER   4
`define BIT_GLOBAL       5
`define BIT_POWER_KEY    8
`define BIT_SLEEP_KEY    9
`define BIT_ALARM        10
`define BIT_WAKE         15

// Implemented bit masks; everything else reads zero
`define STATUS_MASK      16'h8731
`define ENABLE_MASK      16'h0721
`define ENABLE_RESET     16'h0000

// Power states
`define ST_WORKING       3'h0
`define ST_SLEEP1        3'h1
`define ST_SLEEP2        3'h2
`define ST_SLEEP3        3'h3
`define ST_SLEEP4        3'h4
`define ST_SOFT_OFF      3'h5

// Override hold time
`define OVERRIDE_MS      4000
`define CLOCK_MHZ        200
`define OVERRIDE_CYCLES  (`OVERRIDE_MS * 1000 * `CLOCK_MHZ)

`endif

// [testbench/power_event_props.sv]
`timescale 1ns/100ps
module power_event_props (
   // Clock and reset
   input logic        clock,
   input logic        nrst,
   // Observed ports
   input logic [1:0]  reg_select,
   input logic        sleep_enter,
   input logic        power_key_pin,
   input logic        event_route_select,
   input logic [15:0] read_data,
   input logic        os_event_interrupt,
   input logic        firmware_event_interrupt,
   input logic [2:0]  power_state
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   status_rsvd_a: assert property (
      $past(reg_select) == 2'h0 |-> (read_data & 16'h70C0) == 16'h0)
      else $error("reserved status bit read as one");
   enable_rsvd_a: assert property (
      $past(reg_select) inside {2'h1, 2'h2}
      |-> (read_data & 16'hF81E) == 16'h0)
      else $error("reserved enable bit read as one");
   unmapped_zero_a: assert property (
      $past(reg_select) == 2'h3 |-> read_data == 16'h0)
      else $error("unmapped register read nonzero");
   route_os_a: assert property (
      os_event_interrupt |-> $past(event_route_select))
      else $error("os interrupt while routed to firmware");
   route_fw_a: assert property (
      firmware_event_interrupt |-> !$past(event_route_select))
      else $error("firmware interrupt while routed to os");
   one_route_a: assert property (
      !(os_event_interrupt && firmware_event_interrupt))
      else $error("both interrupt targets raised");
   quiet_asleep_a: assert property (
      power_state != 3'h0 && $past(power_state) != 3'h0
      |-> !os_event_interrupt && !firmware_event_interrupt)
      else $error("interrupt raised outside working state");
   soft_off_entry_a: assert property (
      power_state == 3'h5 && $past(power_state) != 3'h5
      |-> $past(sleep_enter) || $past(power_key_pin, 3))
      else $error("soft-off entered without cause");
endmodule // power_event_props

bind power_event_status_enable power_event_props u_props (.*);

// [testbench/tb_top.sv]
`timescale 1ns/100ps
`include "power_event_defs.vh"
module tb_top;
   logic        clock = 0, nrst = 0, reg_select_valid = 0, reg_write = 0;
   logic [1:0]  reg_select = 0, byte_enable = 0;
   logic [15:0] write_data = 0, read_data;
   logic        power_key_pin = 0, sleep_key_pin = 0, alarm_request = 0;
   logic        counter_msb = 0, global_attention_set = 0;
   logic        bus_master_request = 0, event_route_select = 1;
   logic        deep_sleep_alarm_wake_flag = 0, sleep_enter = 0;
   logic [2:0]  sleep_type = 0, power_state;
   logic        os_event_interrupt, firmware_event_interrupt;
   integer      num_errors = 0, num_checks = 0, st = 0, en = 0, v, i;
   integer      seed = 32'h836c;
   power_event_status_enable #(.OVERRIDE_CYCLES(50)) u_dut (.*);
   always #2.5 clock = ~clock;
   task cyc(input integer n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("wrong value %s exp %h seen %h", n, e, s);
      end
   endtask
   task wr(input [1:0] s, input [1:0] b, input [15:0] d);
      cyc(1);
      {reg_select_valid, reg_write, reg_select} = {2'b11, s};
      {byte_enable, write_data} = {b, d};
      cyc(1);
      reg_select_valid = 0;
   endtask
   task rd(input [1:0] s, input [15:0] e);
      cyc(1);
      {reg_select_valid, reg_write, reg_select} = {2'b10, s};
      cyc(1);
      reg_select_valid = 0;
      chk("read_data", read_data, e);
   endtask
   // Press one of power (1), sleep (2) or alarm (4) for n cycles
   task hold(input integer k, input integer n);
      {alarm_request, sleep_key_pin, power_key_pin} = k[2:0];
      cyc(n);
      {alarm_request, sleep_key_pin, power_key_pin} = 3'h0;
      cyc(6);
   endtask
   task nap(input [2:0] t);
      {sleep_type, sleep_enter} = {t, 1'b1};
      cyc(1);
      sleep_enter = 0;
      cyc(3);
   endtask
   task conclude;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #50000;
      num_errors++;
      conclude;
   end
   initial begin
      cyc(8);
      nrst = 1;
      rd(0, 0);
      rd(1, 0);
      rd(3, 0);
      wr(1, 3, 16'hFFFF);
      en = `ENABLE_MASK;
      rd(1, en);
      wr(1, 2, 16'h0000);
      en = en & 16'h00FF;
      rd(1, en);
      // Random counter edges and attention pulses
      for (i = 0; i < 16; i++) begin
         v = $random(seed);
         if (v[0] != counter_msb) st = st | 1;
         if (v[1]) st = st | 16'h20;
         {global_attention_set, counter_msb} = v[1:0];
         cyc(1);
      end
      global_attention_set = 0;
      rd(0, st);
      chk("os", os_event_interrupt, (st & en) != 0);
      event_route_select = 0;
      cyc(2);
      chk("fw", firmware_event_interrupt, (st & en) != 0);
      wr(1, 3, 16'h0000);
      event_route_select = 1;
      wr(0, 3, 16'hFFFF);
      st = 0;
      rd(0, st);
      chk("os", os_event_interrupt, 0);
      hold(1, 4);
      st = 16'h0100;
      rd(0, st);
      chk("os", os_event_interrupt, 0);
      wr(1, 3, 16'h0100);
      cyc(1);
      chk("os", os_event_interrupt, 1);
      wr(0, 3, 16'h0000);
      rd(0, st);
      wr(0, 1, 16'h0100);
      rd(0, st);
      wr(0, 2, 16'h0100);
      st = 0;
      rd(0, st);
      hold(2, 4);
      hold(4, 4);
      st = 16'h0600;
      rd(0, st);
      wr(1, 3, 16'h0400);
      cyc(1);
      chk("os", os_event_interrupt, 1);
      wr(0, 3, 16'hFFFF);
      wr(1, 3, 16'h0000);
      nap(3);
      hold(2, 4);
      chk("state", power_state, 3);
      hold(1, 4);
      chk("state", power_state, 0);
      rd(0, 16'h8300);
      wr(0, 3, 16'hFFFF);
      wr(1, 3, 16'h0200);
      nap(1);
      hold(2, 4);
      chk("state", power_state, 0);
      rd(0, 16'h8200);
      wr(0, 3, 16'hFFFF);
      hold(1, 70);
      chk("state", power_state, 5);
      rd(0, 0);
      rd(1, 0);
      // Wake from soft-off clears the enables again
      wr(1, 3, 16'h0400);
      hold(1, 4);
      chk("state", power_state, 0);
      rd(1, 0);
      // Alarm wake from sleep 4 needs the configuration flag
      wr(0, 3, 16'hFFFF);
      wr(1, 3, 16'h0400);
      nap(4);
      hold(4, 4);
      chk("state", power_state, 4);
      deep_sleep_alarm_wake_flag = 1;
      hold(4, 4);
      chk("state", power_state, 0);
      rd(0, 16'h8400);
      // Bus-master flag sets but never interrupts
      wr(0, 3, 16'hFFFF);
      wr(1, 3, 16'h0010);
      rd(1, 0);
      bus_master_request = 1;
      cyc(1);
      bus_master_request = 0;
      rd(0, 16'h0010);
      chk("os", os_event_interrupt, 0);
      conclude;
   end
endmodule // tb_top
